// file: ccrb_ctrl.sv
// Notes on behaviour
// - writing 1 to bit 15 returns all converter state to power-on values
// - master reset bit clears itself 2 clocks after the write; writing 0 does nothing
// - reading the master reset bit always gives 0
// - system reset also puts the converter module into its reset state
// - enable bit 14 at 0 stops conversions but keeps converter powered
// - busy flag bit 13 sets when a start-of-conversion is generated
// - sequencer may start a new sample only while busy shows available
// - busy clears 4 converter clocks after hold fall, 14 in simultaneous mode
// - bits 12-8 show channel in progress while busy, else last channel
`timescale 1ns/1ns
`default_nettype none

module ccrb_ctrl
  import ccrb_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  input  wire logic              i_soc_req,
  input  wire logic [CHAN_W-1:0] i_soc_chan,
  input  wire logic              i_sim_mode,
  input  wire logic              i_sh_fall,
  input  wire logic              i_conv_tick,
  output logic                   o_soc_ready,
  output logic                   o_soc_start,
  output logic                   o_busy,
  output logic      [CHAN_W-1:0] o_busy_chan,
  output logic                   o_enable,
  output logic      [LOW_W-1:0]  o_low_cfg,
  output logic                   o_module_rst_n
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [DATA_W-1:0] rd_word(input ccrb_state_t st);
    logic [DATA_W-1:0] w;
    w = '0;
    w[BIT_EN] = st.enable;
    w[BIT_BSY] = (st.phase != PH_IDLE);
    w[CHN_LSB +: CHAN_W] = st.chan;
    w[LOW_W-1:0] = st.low & LOW_WMASK;
    return w;
  endfunction : rd_word

  ccrb_state_t s_r;
  ccrb_state_t s_nxt;
  logic        ctl_wr;
  logic        soc_ready;

  assign ctl_wr    = i_wr && (i_addr == CTL1_OFS);
  // sampling is gated by enable, idle converter and no reset in flight
  assign soc_ready = s_r.enable && (s_r.phase == PH_IDLE) && (s_r.rst_cnt == 2'h0);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = '0;
    case (s_r.phase)
      PH_IDLE: begin
        if (soc_ready && i_soc_req) begin
          s_nxt.phase = PH_SAMPLE;
          s_nxt.chan = i_soc_chan;
          s_nxt.sim = i_sim_mode;
        end
      end
      PH_SAMPLE: begin
        if (i_sh_fall) begin
          s_nxt.phase = PH_SETTLE;
          s_nxt.clr_cnt = s_r.sim ? SIM_CLR_CLKS : SEQ_CLR_CLKS;
        end
      end
      PH_SETTLE: begin
        if (i_conv_tick) begin
          s_nxt.clr_cnt = s_r.clr_cnt - 4'h1;
          if (s_r.clr_cnt == 4'h1) begin
            s_nxt.phase = PH_IDLE;
          end
        end
      end
      default: begin
        s_nxt.phase = PH_IDLE;
      end
    endcase
    if (s_r.rst_cnt != 2'h0) begin
      // hold the module in reset; writes during latency are dropped
      s_nxt = STATE_INIT;
      s_nxt.rst_cnt = s_r.rst_cnt - 2'h1;
    end else if (ctl_wr) begin
      if (i_wdata[BIT_RST]) begin
        s_nxt = STATE_INIT;
        s_nxt.rst_cnt = RST_HOLD;
      end else begin
        // busy and channel bits are not writable
        s_nxt.enable = i_wdata[BIT_EN];
        s_nxt.low = i_wdata[LOW_W-1:0] & LOW_WMASK;
      end
    end
    if (i_rd) begin
      if (i_addr == CTL1_OFS) begin
        s_nxt.rdata = rd_word(s_r);
      end else begin
        s_nxt.rdata = '0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= STATE_INIT;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign o_rdata        = s_r.rdata;
  assign o_soc_ready    = soc_ready;
  assign o_soc_start    = soc_ready && i_soc_req;
  assign o_busy         = (s_r.phase != PH_IDLE);
  assign o_busy_chan    = s_r.chan;
  assign o_enable       = s_r.enable;
  assign o_low_cfg      = s_r.low & LOW_WMASK;
  assign o_module_rst_n = (s_r.rst_cnt == 2'h0);

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  soft_reset_clears_a: assert property (
    (ctl_wr && i_wdata[BIT_RST] && s_r.rst_cnt == 2'h0) |=>
      (!s_r.enable && !o_busy && s_r.low == 8'h00 && o_busy_chan == 5'h00 && !o_module_rst_n))
    else $error("master reset left state behind");

  hold_blocks_start_a: assert property (
    (s_r.rst_cnt != 2'h0) |-> (!o_soc_ready && !o_soc_start))
    else $error("start allowed during master reset");

  reset_self_clear_a: assert property (
    (ctl_wr && i_wdata[BIT_RST] && s_r.rst_cnt == 2'h0) |=> ##1 o_module_rst_n)
    else $error("master reset did not clear itself");

  zero_write_a: assert property (
    (ctl_wr && !i_wdata[BIT_RST] && o_module_rst_n) |=> o_module_rst_n)
    else $error("writing 0 to reset bit acted");

  reset_reads_zero_a: assert property (
    $past(i_rd) |-> !o_rdata[BIT_RST])
    else $error("reset bit read back as 1");

  sys_reset_idle_a: assert property (
    $rose(i_rst_n) |-> (!o_busy && !o_enable && o_module_rst_n))
    else $error("module not idle after system reset");

  disabled_no_start_a: assert property (
    !s_r.enable |-> (!o_soc_start && !o_soc_ready))
    else $error("conversion started while disabled");

  enable_write_a: assert property (
    (ctl_wr && !i_wdata[BIT_RST] && s_r.rst_cnt == 2'h0) |=> (o_enable == $past(i_wdata[BIT_EN])))
    else $error("enable bit write did not land");

  // a soft-reset write in the start cycle wins, so it is left out
  busy_on_soc_a: assert property (
    (o_soc_start && !(ctl_wr && i_wdata[BIT_RST])) |=> (o_busy && o_busy_chan == $past(i_soc_chan)))
    else $error("busy or channel not set by start");

  no_start_busy_a: assert property (
    o_busy |-> !o_soc_ready)
    else $error("sampling allowed while busy");

  ready_when_idle_a: assert property (
    (s_r.enable && !o_busy && o_module_rst_n) |-> o_soc_ready)
    else $error("available converter refused a start");

  // tick-exact timing lives in the counter: pin its load, its hold and its last step
  seq_clear_load_a: assert property (
    (s_r.phase == PH_SAMPLE && i_sh_fall && !s_r.sim && !ctl_wr && s_r.rst_cnt == 2'h0)
      |=> (o_busy && s_r.clr_cnt == SEQ_CLR_CLKS))
    else $error("sequential busy clear count wrong");

  sim_clear_load_a: assert property (
    (s_r.phase == PH_SAMPLE && i_sh_fall && s_r.sim && !ctl_wr && s_r.rst_cnt == 2'h0)
      |=> (o_busy && s_r.clr_cnt == SIM_CLR_CLKS))
    else $error("simultaneous busy clear count wrong");

  busy_stays_a: assert property (
    (s_r.phase == PH_SETTLE && s_r.clr_cnt > 4'h1 && !ctl_wr && s_r.rst_cnt == 2'h0) |=> o_busy)
    else $error("busy cleared early");

  busy_clear_last_a: assert property (
    (s_r.phase == PH_SETTLE && i_conv_tick && s_r.clr_cnt == 4'h1) |=> !o_busy)
    else $error("busy not cleared on last tick");

  chan_hold_a: assert property (
    (!o_busy && !o_soc_start && !ctl_wr && s_r.rst_cnt == 2'h0) |=> $stable(o_busy_chan))
    else $error("last channel not held");

  busy_write_a: assert property (
    (ctl_wr && !i_wdata[BIT_RST] && !o_busy && !o_soc_start && s_r.rst_cnt == 2'h0) |=> !o_busy)
    else $error("software write changed busy");

  // read data stand one cycle only, so a late sampler sees zero rather than stale data
  rdata_idle_a: assert property (
    !i_rd |=> (o_rdata == 16'h0000))
    else $error("read data stood without a read");

  unmapped_read_a: assert property (
    (i_rd && i_addr != CTL1_OFS) |=> (o_rdata == 16'h0000))
    else $error("unmapped read returned data");

endmodule : ccrb_ctrl

`default_nettype wire

// file: ccrb_pkg.sv
package ccrb_pkg;

  // ************************************************************
  // register map and field layout
  // ************************************************************
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned CHAN_W       = 5;
  localparam int unsigned LOW_W        = 8;
  localparam logic [7:0]  CTL1_OFS     = 8'h00;
  localparam int unsigned BIT_RST      = 15;
  localparam int unsigned BIT_EN       = 14;
  localparam int unsigned BIT_BSY      = 13;
  localparam int unsigned CHN_LSB      = 8;
  localparam logic [7:0]  LOW_WMASK    = 8'hef;
  localparam logic [15:0] CTL1_RESET   = 16'h0000;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned RST_LAT_CYC  = 2;
  localparam logic [1:0]  RST_HOLD     = 2'(RST_LAT_CYC - 1);
  localparam int unsigned CLR_W        = 4;
  localparam logic [3:0]  SEQ_CLR_CLKS = 4'h4;
  localparam logic [3:0]  SIM_CLR_CLKS = 4'he;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_SAMPLE = 2'b01,
    PH_SETTLE = 2'b10
  } ccrb_phase_t;

  typedef struct packed {
    logic                enable;
    logic [LOW_W-1:0]    low;
    ccrb_phase_t         phase;
    logic [CHAN_W-1:0]   chan;
    logic                sim;
    logic [CLR_W-1:0]    clr_cnt;
    logic [1:0]          rst_cnt;
    logic [DATA_W-1:0]   rdata;
  } ccrb_state_t;

  localparam ccrb_state_t STATE_INIT = '{
    enable:  1'b0,
    low:     CTL1_RESET[7:0],
    phase:   PH_IDLE,
    chan:    5'h00,
    sim:     1'b0,
    clr_cnt: 4'h0,
    rst_cnt: 2'h0,
    rdata:   16'h0000
  };

endpackage : ccrb_pkg

// file: ccrb_ctrl_dummy_unused.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// file: ccrb_ctrl_bench.sv
`timescale 1ns/1ns
`default_nettype none
module ccrb_ctrl_bench
  import ccrb_pkg::*;
;
  logic              clk, rst_n, wr, rd, req, sim, shf, tick;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [CHAN_W-1:0] chan, bchan;
  logic [LOW_W-1:0]  low;
  logic              ready, start, busy, en, mrst_n;
  int                n_fail, cmp_count;

  ccrb_ctrl ccrb_ctrl_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_soc_req(req), .i_soc_chan(chan), .i_sim_mode(sim),
    .i_sh_fall(shf), .i_conv_tick(tick), .o_soc_ready(ready), .o_soc_start(start), .o_busy(busy),
    .o_busy_chan(bchan), .o_enable(en), .o_low_cfg(low), .o_module_rst_n(mrst_n));

  // ************************************************************
  // helpers
  // ************************************************************
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task rd_reg(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", rdata, exp);
  endtask : rd_reg

  task pulse(input logic use_tick);
    @(posedge clk);
    if (use_tick) tick <= 1'b1;
    else shf <= 1'b1;
    @(posedge clk);
    shf <= 1'b0;
    tick <= 1'b0;
  endtask : pulse

  task conv(input logic m, input logic [4:0] ch, input int n);
    @(posedge clk);
    req <= 1'b1;
    chan <= ch;
    sim <= m;
    #1 chk("start", 16'(start), 16'h0001);
    @(posedge clk);
    req <= 1'b0;
    #1 chk("busy", 16'(busy), 16'h0001);
    chk("chan", 16'(bchan), 16'(ch));
    chk("ready", 16'(ready), 16'h0000);
    pulse(1'b0);
    for (int i = 1; i <= n; i++) begin
      pulse(1'b1);
      #1 chk("busy_cnt", 16'(busy), 16'(i < n));
    end
    chk("chan_hold", 16'(bchan), 16'(ch));
    chk("ready_back", 16'(ready), 16'h0001);
  endtask : conv

  // ************************************************************
  // stimulus
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #100000;
    n_fail++;
    summarize();
  end

  initial begin
    {rst_n, wr, rd, req, sim, shf, tick} = '0;
    addr = 8'h00;
    wdata = 16'h0000;
    chan = 5'h00;
    n_fail = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("mrst", 16'(mrst_n), 16'h0001);
    chk("ready0", 16'(ready), 16'h0000);
    rd_reg(CTL1_OFS, CTL1_RESET);
    wr_reg(CTL1_OFS, 16'h60ff);
    rd_reg(CTL1_OFS, 16'h40ef);
    chk("low", 16'(low), 16'h00ef);
    chk("en", 16'(en), 16'h0001);
    rd_reg(8'h10, 16'h0000);
    conv(1'b0, 5'h03, 4);
    conv(1'b1, 5'h1f, 14);
    rd_reg(CTL1_OFS, 16'h5fef);
    wr_reg(CTL1_OFS, 16'h4000);
    #1 chk("no_rst", 16'(mrst_n), 16'h0001);
    @(posedge clk);
    req <= 1'b1;
    chan <= 5'h02;
    @(posedge clk);
    req <= 1'b0;
    wr_reg(CTL1_OFS, 16'hc0ff);
    #1 chk("soft_rst", 16'(mrst_n), 16'h0000);
    chk("rst_busy", 16'(busy), 16'h0000);
    rd_reg(CTL1_OFS, 16'h0000);
    chk("rst_done", 16'(mrst_n), 16'h0001);
    wr_reg(CTL1_OFS, 16'h0000);
    @(posedge clk);
    req <= 1'b1;
    #1 chk("dis_start", 16'(start), 16'h0000);
    @(posedge clk);
    req <= 1'b0;
    wr_reg(CTL1_OFS, 16'h40ef);
    #1 chk("en_set", 16'(en), 16'h0001);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("sys_rst_en", 16'(en), 16'h0000);
    chk("sys_rst_low", 16'(low), 16'h0000);
    rd_reg(CTL1_OFS, CTL1_RESET);
    summarize();
  end
endmodule : ccrb_ctrl_bench
`default_nettype wire
